// *** logic/temp_conversion_sequencer.sv ***
// Conversion sequencer: hold-off, modes, averaging, result, bus timeout
//
// Contract
// - No conversion before 1.5 ms power-up hold-off
// - Result reads minus 256 C until first
// - Strap makes device start in shutdown
// - Averaging code 01 publishes mean of eight
// - Each conversion lasts 15.5 ms, scales active
// - Cycle is active time then standby
// - Defaults: eight averages, one second cycle
// - Averaging applies in continuous and one-shot
// - Release data line after idle clock timeout
// - Reset takes 1.5 ms before normal operation
// - Mode field selects continuous, shutdown, one-shot
// - Result updated when each conversion or average of eight completes, 16-bit two's complement
// - One-shot returns to shutdown, no standby
// - Done flag set; cleared by config/result read
`timescale 1ns/1ps
module temp_conversion_sequencer
  import tconv_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYC = HOLDOFF_CYCLES,
  parameter int unsigned CONV_CYC    = CONV_CYCLES,
  parameter int unsigned TIMEOUT_CYC = BUS_TIMEOUT_CYCLES,
  parameter int unsigned MS_CYC      = MS_CYCLES
)
(
  // Clock and reset (supply power-on / brownout)
  input  wire logic                clk_sys_i,
  input  wire logic                reset_i,
  // Start-up strap
  input  wire logic                startup_shutdown_i,
  // Configuration access
  input  wire logic                cfg_write_i,
  input  wire cfg_s                cfg_wdata_i,
  input  wire logic                cfg_read_i,
  input  wire logic                result_read_i,
  // Converter sample
  input  wire logic [RESULT_W-1:0] adc_sample_i,
  // Two-wire bus
  input  wire logic                scl_i,
  input  wire logic                bus_active_i,
  input  wire logic                sda_pull_low_i,
  // Status
  output cfg_s                     cfg_o,
  output logic [RESULT_W-1:0]      result_o,
  output logic                     data_ready_o,
  output logic                     conv_active_o,
  output logic                     power_down_mode_o,
  output logic                     single_conversion_mode_o,
  output logic                     ready_o,
  // Serial data pin
  output logic                     sda_o,
  output logic                     sda_oe_o,
  output logic                     bus_timeout_o
);

  seq_state_e         state_q;
  cfg_s               cfg_q;
  logic [IDX_W-1:0]   idx_q;
  logic               eight_q;
  logic               oneshot_q;
  logic [TIMER_W-1:0] period_q;

  logic               tmr_load;
  logic               tmr_stop;
  logic [TIMER_W-1:0] tmr_cycles;
  logic               tmr_expire;
  logic               avg_clear;
  logic               avg_add;
  logic               avg_last;
  logic [RESULT_W-1:0] avg_mean;
  logic               avg_valid;

  logic               mode_cont;
  logic               mode_sd;
  logic               mode_os;
  logic               eight_sel;
  logic [TIMER_W-1:0] active_total;
  logic [TIMER_W-1:0] standby_cyc;
  logic               hw_to_shutdown;

  // Mode decode
  always_comb begin
    mode_cont = (cfg_q.conversion_mode_select == MODE_CONT) ||
                (cfg_q.conversion_mode_select == MODE_CONT_ALT);
    mode_sd   = cfg_q.conversion_mode_select == MODE_SHUTDOWN;
    mode_os   = cfg_q.conversion_mode_select == MODE_ONESHOT;
    eight_sel = cfg_q.averaging_select == AVG_EIGHT;
  end

  // Active time scales with averaging count
  always_comb begin
    active_total = eight_q ? TIMER_W'(CONV_CYC) * AVG_COUNT_8
                           : TIMER_W'(CONV_CYC);
    standby_cyc  = (period_q > active_total) ? period_q - active_total
                                             : '0;
  end

  // Sequencer state
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_BOOT;
    end else begin
      unique case (state_q)
        ST_BOOT: begin
          state_q <= ST_HOLD;
        end
        ST_HOLD: begin
          if (tmr_expire) begin
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!mode_sd) begin
            state_q <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (mode_sd) begin
            state_q <= ST_IDLE;
          end else if (tmr_expire && avg_last) begin
            state_q <= oneshot_q ? ST_IDLE : ST_STANDBY;
          end
        end
        ST_STANDBY: begin
          if (!mode_cont || tmr_expire) begin
            state_q <= (mode_cont && tmr_expire) ? ST_ACTIVE : ST_IDLE;
          end
        end
      endcase
    end
  end

  // Timer requests
  always_comb begin
    tmr_load   = 1'b0;
    tmr_stop   = 1'b0;
    tmr_cycles = TIMER_W'(CONV_CYC);
    unique case (state_q)
      ST_BOOT: begin
        tmr_load   = 1'b1;
        tmr_cycles = TIMER_W'(HOLDOFF_CYC);
      end
      ST_HOLD: begin
      end
      ST_IDLE: begin
        tmr_load = !mode_sd;
      end
      ST_ACTIVE: begin
        if (mode_sd) begin
          tmr_stop = 1'b1;
        end else if (tmr_expire && !avg_last) begin
          tmr_load = 1'b1;
        end else if (tmr_expire && !oneshot_q) begin
          tmr_load   = 1'b1;
          tmr_cycles = standby_cyc;
        end
      end
      ST_STANDBY: begin
        if (!mode_cont) begin
          tmr_stop = 1'b1;
        end else if (tmr_expire) begin
          tmr_load = 1'b1;
        end
      end
    endcase
  end

  // Averaging bookkeeping
  always_comb begin
    avg_last  = idx_q == (eight_q ? AVG_LAST_8 : AVG_LAST_1);
    avg_add   = (state_q == ST_ACTIVE) && tmr_expire && !mode_sd;
    avg_clear = (state_q != ST_ACTIVE) || mode_sd;
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      idx_q     <= '0;
      eight_q   <= 1'b1;
      oneshot_q <= 1'b0;
      period_q  <= '0;
    end else if (state_q != ST_ACTIVE) begin
      // Settings latched at the start of each active period
      idx_q     <= '0;
      eight_q   <= eight_sel;
      oneshot_q <= mode_os;
      period_q  <= TIMER_W'(PERIOD_MS[cfg_q.cycle_period_select]) *
                   TIMER_W'(MS_CYC);
    end else if (avg_add) begin
      idx_q <= avg_last ? '0 : idx_q + IDX_W'(1);
    end
  end

  // Shutdown entered by the sequencer itself
  always_comb begin
    hw_to_shutdown = ((state_q == ST_HOLD) && tmr_expire &&
                      startup_shutdown_i) ||
                     ((state_q == ST_ACTIVE) && avg_add && avg_last &&
                      oneshot_q);
  end

  // Configuration; host write wins over the sequencer
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_q <= CFG_RESET;
    end else if (cfg_write_i) begin
      cfg_q <= cfg_wdata_i;
    end else if (hw_to_shutdown) begin
      cfg_q.conversion_mode_select <= MODE_SHUTDOWN;
    end
  end

  tconv_timer u_timer (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .load_i    (tmr_load),
    .stop_i    (tmr_stop),
    .cycles_i  (tmr_cycles),
    .expire_o  (tmr_expire)
  );

  tconv_average u_average (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .clear_i   (avg_clear),
    .add_i     (avg_add),
    .last_i    (avg_last),
    .eight_i   (eight_q),
    .sample_i  (adc_sample_i),
    .mean_o    (avg_mean),
    .valid_o   (avg_valid)
  );

  // Result register
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      result_o <= RESULT_RESET;
    end else if (avg_valid) begin
      result_o <= avg_mean;
    end
  end

  // Done flag; a new result wins over a clearing read
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      data_ready_o <= 1'b0;
    end else if (avg_valid) begin
      data_ready_o <= 1'b1;
    end else if (cfg_read_i || result_read_i) begin
      data_ready_o <= 1'b0;
    end
  end

  // Status outputs
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_o                    <= CFG_RESET;
      conv_active_o            <= 1'b0;
      power_down_mode_o        <= 1'b0;
      single_conversion_mode_o <= 1'b0;
      ready_o                  <= 1'b0;
    end else begin
      cfg_o                    <= cfg_q;
      conv_active_o            <= (state_q == ST_ACTIVE) && !mode_sd;
      power_down_mode_o        <= (state_q == ST_IDLE) && mode_sd;
      single_conversion_mode_o <= (state_q == ST_ACTIVE) && oneshot_q;
      ready_o                  <= (state_q != ST_BOOT) &&
                                  (state_q != ST_HOLD);
    end
  end

  // Bus clock idle timeout
  logic              scl_q;
  logic [TOUT_W-1:0] idle_q;
  logic              tout_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q  <= 1'b1;
      idle_q <= '0;
      tout_q <= 1'b0;
    end else begin
      scl_q <= scl_i;
      if (!bus_active_i) begin
        idle_q <= '0;
        tout_q <= 1'b0;
      end else if (scl_i != scl_q) begin
        idle_q <= '0;
      end else if (idle_q >= TOUT_W'(TIMEOUT_CYC - 1)) begin
        tout_q <= 1'b1;
      end else begin
        idle_q <= idle_q + TOUT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sda_o         <= 1'b0;
      sda_oe_o      <= 1'b0;
      bus_timeout_o <= 1'b0;
    end else begin
      sda_o         <= 1'b0;
      sda_oe_o      <= sda_pull_low_i && !tout_q;
      bus_timeout_o <= tout_q;
    end
  end

endmodule

// *** logic/tconv_pkg.sv ***
// Shared constants and types of the temperature conversion sequencer
package tconv_pkg;

  // Timebase
  localparam real         CLK_HZ           = 250.0e6;
  localparam real         HOLDOFF_MS       = 1.5;
  localparam real         CONV_TIME_MS     = 15.5;
  localparam real         BUS_TIMEOUT_MIN_MS = 20.0;
  localparam real         BUS_TIMEOUT_MAX_MS = 40.0;
  localparam int unsigned HOLDOFF_CYCLES   =
    int'($ceil(HOLDOFF_MS * CLK_HZ / 1000.0));
  localparam int unsigned CONV_CYCLES      =
    int'($floor(CONV_TIME_MS * CLK_HZ / 1000.0 + 0.5));
  localparam int unsigned BUS_TIMEOUT_CYCLES =
    int'($ceil(BUS_TIMEOUT_MIN_MS * CLK_HZ / 1000.0));
  localparam int unsigned MS_CYCLES        =
    int'($ceil(CLK_HZ / 1000.0));

  // Widths
  localparam int TIMER_W  = 32;
  localparam int RESULT_W = 16;
  localparam int SUM_W    = 19;
  localparam int IDX_W    = 3;
  localparam int TOUT_W   = 24;

  // Averaging
  localparam logic [1:0]       AVG_NONE   = 2'h0;
  localparam logic [1:0]       AVG_EIGHT  = 2'h1;
  localparam logic [IDX_W-1:0] AVG_LAST_8 = 3'h7;
  localparam logic [IDX_W-1:0] AVG_LAST_1 = 3'h0;
  localparam int               AVG_SHIFT  = 3;
  localparam logic [TIMER_W-1:0] AVG_COUNT_8 = 32'h0000_0008;

  // Conversion mode field codes
  localparam logic [1:0] MODE_CONT     = 2'h0;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h1;
  localparam logic [1:0] MODE_CONT_ALT = 2'h2;
  localparam logic [1:0] MODE_ONESHOT  = 2'h3;

  // Cycle period per cycle_period_select value, in milliseconds
  localparam int unsigned PERIOD_MS [8] =
    '{16, 125, 250, 500, 1000, 4000, 8000, 16000};

  // Reset values
  localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h8000;
  localparam logic [1:0]          AVG_DEFAULT  = AVG_EIGHT;
  localparam logic [2:0]          CONV_DEFAULT = 3'h4;
  localparam logic [1:0]          MODE_DEFAULT = MODE_CONT;

  typedef struct packed {
    logic [1:0] conversion_mode_select;
    logic [1:0] averaging_select;
    logic [2:0] cycle_period_select;
  } cfg_s;

  localparam cfg_s CFG_RESET = '{
    conversion_mode_select: MODE_DEFAULT,
    averaging_select:       AVG_DEFAULT,
    cycle_period_select:    CONV_DEFAULT
  };

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_HOLD,
    ST_IDLE,
    ST_ACTIVE,
    ST_STANDBY
  } seq_state_e;

endpackage

// *** logic/tconv_timer.sv ***
// Down counter that pulses once after a loaded number of cycles
`timescale 1ns/1ps
module tconv_timer
  import tconv_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               reset_i,
  // Control
  input  wire logic               load_i,
  input  wire logic               stop_i,
  input  wire logic [TIMER_W-1:0] cycles_i,
  // Status
  output logic                    expire_o
);

  logic [TIMER_W-1:0] cnt_q;
  logic               run_q;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (load_i) begin
      // Zero is treated as one cycle
      cnt_q <= (cycles_i == '0) ? '0 : cycles_i - TIMER_W'(1);
      run_q <= 1'b1;
    end else if (stop_i) begin
      run_q <= 1'b0;
    end else if (run_q) begin
      if (cnt_q == '0) begin
        run_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - TIMER_W'(1);
      end
    end
  end

  // Seen exactly the loaded number of cycles after the load edge
  assign expire_o = run_q && (cnt_q == '0);

endmodule

// *** logic/tconv_average.sv ***
// Accumulator that publishes the mean of one or eight samples
`timescale 1ns/1ps
module tconv_average
  import tconv_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                reset_i,
  // Control
  input  wire logic                clear_i,
  input  wire logic                add_i,
  input  wire logic                last_i,
  input  wire logic                eight_i,
  input  wire logic [RESULT_W-1:0] sample_i,
  // Result
  output logic [RESULT_W-1:0]      mean_o,
  output logic                     valid_o
);

  logic signed [SUM_W-1:0] sum_q;
  logic signed [SUM_W-1:0] sum_d;

  always_comb begin
    sum_d = sum_q + SUM_W'(signed'(sample_i));
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sum_q <= '0;
    end else if (clear_i) begin
      sum_q <= '0;
    end else if (add_i) begin
      sum_q <= last_i ? '0 : sum_d;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      mean_o  <= RESULT_RESET;
      valid_o <= 1'b0;
    end else begin
      valid_o <= add_i && last_i && !clear_i;
      if (add_i && last_i && !clear_i) begin
        // Arithmetic shift keeps negative means correct
        mean_o <= eight_i ? RESULT_W'(sum_d >>> AVG_SHIFT) : sample_i;
      end
    end
  end

endmodule

// *** verif/tconv_checker_assertions.sv ***
// Port checker for the conversion sequencer
`timescale 1ns/1ps
module tconv_checker
  import tconv_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYC = 20,
  parameter int unsigned TIMEOUT_CYC = 30
)
(
  // Sequencer inputs
  input wire logic                clk_sys_i,
  input wire logic                reset_i,
  input wire logic                cfg_write_i,
  input wire cfg_s                cfg_wdata_i,
  input wire logic                cfg_read_i,
  input wire logic                result_read_i,
  input wire logic                scl_i,
  input wire logic                bus_active_i,
  // Sequencer outputs
  input wire logic [RESULT_W-1:0] result_o,
  input wire logic                data_ready_o,
  input wire logic                conv_active_o,
  input wire logic                power_down_mode_o,
  input wire logic                single_conversion_mode_o,
  input wire logic                ready_o,
  input wire logic                sda_oe_o,
  input wire logic                bus_timeout_o
);
  logic [31:0] up_q;
  logic [31:0] idle_q;
  logic        scl_q;

  // Cycles since reset release
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      up_q <= 32'h0;
    end else if (up_q != 32'hffff_ffff) begin
      up_q <= up_q + 32'h1;
    end
  end

  // Cycles of a frozen bus clock inside a transfer
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      scl_q  <= 1'b1;
      idle_q <= 32'h0;
    end else begin
      scl_q <= scl_i;
      if (!bus_active_i || scl_i != scl_q) begin
        idle_q <= 32'h0;
      end else if (idle_q != 32'hffff_ffff) begin
        idle_q <= idle_q + 32'h1;
      end
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  AST_NO_EARLY: assert property (
    !ready_o |-> !conv_active_o)
    else $error("conversion before ready");
  AST_RESET_CODE: assert property (
    !ready_o |-> result_o == RESULT_RESET)
    else $error("result not at reset code");
  AST_READY_TIME: assert property (
    $rose(ready_o) |-> up_q >= HOLDOFF_CYC && up_q <= HOLDOFF_CYC + 4)
    else $error("ready at wrong time");
  AST_ABORT: assert property (
    cfg_write_i && cfg_wdata_i.conversion_mode_select == MODE_SHUTDOWN
    |-> ##[1:3] !conv_active_o)
    else $error("shutdown did not abort");
  AST_OS_END: assert property (
    $fell(single_conversion_mode_o) |-> ##[0:4] power_down_mode_o)
    else $error("one-shot did not return to shutdown");
  AST_PUB_FLAG: assert property (
    $changed(result_o) |-> data_ready_o)
    else $error("publish without done flag");
  AST_READ_CLR: assert property (
    (cfg_read_i || result_read_i) && power_down_mode_o
    |-> ##[1:2] !data_ready_o)
    else $error("read did not clear done flag");
  AST_TMO_HIT: assert property (
    idle_q >= TIMEOUT_CYC + 3 |-> bus_timeout_o && !sda_oe_o)
    else $error("data line not released");
  AST_TMO_EARLY: assert property (
    $rose(bus_timeout_o) |-> idle_q >= TIMEOUT_CYC - 3)
    else $error("timeout too early");
endmodule

bind temp_conversion_sequencer tconv_checker #(
  .HOLDOFF_CYC(HOLDOFF_CYC),
  .TIMEOUT_CYC(TIMEOUT_CYC)
) chk (.clk_sys_i, .reset_i, .cfg_write_i, .cfg_wdata_i, .cfg_read_i,
  .result_read_i, .scl_i, .bus_active_i, .result_o, .data_ready_o,
  .conv_active_o, .power_down_mode_o, .single_conversion_mode_o,
  .ready_o, .sda_oe_o, .bus_timeout_o);

// *** verif/tconv_host.sv ***
// Bus host model that reads results and stalls the bus clock
`timescale 1ns/1ps
module tconv_host
  import tconv_pkg::*;
(
  // Clock and sensed lines
  input  wire logic                clk_sys_i,
  input  wire logic                sda_i,
  input  wire logic [RESULT_W-1:0] result_i,
  // Bus controls
  output logic                     scl_o,
  output logic                     bus_active_o,
  output logic                     sda_pull_low_o,
  output logic                     cfg_read_o,
  output logic                     result_read_o
);
  initial begin
    scl_o          = 1'b1;
    bus_active_o   = 1'b0;
    sda_pull_low_o = 1'b0;
    cfg_read_o     = 1'b0;
    result_read_o  = 1'b0;
  end

  // Clocked register read; either register clears the done flag
  task automatic read_reg(input logic cfg, output logic [15:0] v);
    @(negedge clk_sys_i);
    bus_active_o = 1'b1;
    repeat (4) begin
      @(negedge clk_sys_i);
      scl_o = ~scl_o;
    end
    cfg_read_o    = cfg;
    result_read_o = ~cfg;
    @(negedge clk_sys_i);
    v             = result_i;
    cfg_read_o    = 1'b0;
    result_read_o = 1'b0;
    bus_active_o  = 1'b0;
  endtask

  // Freezes the clock mid-transfer with the data line pulled low
  task automatic stall(input int n, output logic mid, output logic fin);
    @(negedge clk_sys_i);
    bus_active_o   = 1'b1;
    sda_pull_low_o = 1'b1;
    scl_o          = 1'b0;
    repeat (4) @(negedge clk_sys_i);
    mid = sda_i;
    repeat (n) @(negedge clk_sys_i);
    fin            = sda_i;
    sda_pull_low_o = 1'b0;
    bus_active_o   = 1'b0;
    scl_o          = 1'b1;
  endtask
endmodule

// *** verif/tb_top.sv ***
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module tb_top;
  import tconv_pkg::*;
  localparam int unsigned HO = 20;
  localparam int unsigned CV = 10;
  localparam int unsigned TO = 30;
  localparam int unsigned MS = 4;

  logic        clk_sys_i;
  logic        reset_i;
  logic        startup_shutdown_i;
  logic        cfg_write_i;
  cfg_s        cfg_wdata_i;
  logic        cfg_read_i;
  logic        result_read_i;
  logic [15:0] adc_sample_i;
  logic        scl_i;
  logic        bus_active_i;
  logic        sda_pull_low_i;
  cfg_s        cfg_o;
  logic [15:0] result_o;
  logic        data_ready_o;
  logic        conv_active_o;
  logic        power_down_mode_o;
  logic        ready_o;
  logic        sda_o;
  logic        sda_oe_o;
  logic        bus_timeout_o;
  wire         sda_w;
  int          fail_count = 0;
  int          num_checks = 0;

  // Pulled-up data line
  assign sda_w = sda_oe_o ? sda_o : 1'b1;

  temp_conversion_sequencer #(.HOLDOFF_CYC(HO), .CONV_CYC(CV),
    .TIMEOUT_CYC(TO), .MS_CYC(MS)) uut (.clk_sys_i, .reset_i,
    .startup_shutdown_i, .cfg_write_i, .cfg_wdata_i, .cfg_read_i,
    .result_read_i, .adc_sample_i, .scl_i, .bus_active_i,
    .sda_pull_low_i, .cfg_o, .result_o, .data_ready_o, .conv_active_o,
    .power_down_mode_o, .single_conversion_mode_o(), .ready_o, .sda_o,
    .sda_oe_o, .bus_timeout_o);

  tconv_host host (.clk_sys_i, .sda_i(sda_w), .result_i(result_o),
    .scl_o(scl_i), .bus_active_o(bus_active_i),
    .sda_pull_low_o(sda_pull_low_i), .cfg_read_o(cfg_read_i),
    .result_read_o(result_read_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic sd);
    int n;
    @(negedge clk_sys_i);
    reset_i            = 1'b1;
    startup_shutdown_i = sd;
    repeat (6) @(negedge clk_sys_i);
    check(16'(cfg_o), 16'(CFG_RESET));
    reset_i = 1'b0;
    n       = 0;
    while (ready_o !== 1'b1 && n < 200) begin
      @(negedge clk_sys_i);
      n++;
    end
    check(16'(n >= HO && n < 200), 16'h1);
    check(result_o, RESULT_RESET);
    repeat (3) @(negedge clk_sys_i);
    check(16'(power_down_mode_o), 16'(sd));
    check(16'(conv_active_o), 16'(!sd));
  endtask

  task automatic set_cfg(input logic [1:0] m, input logic [1:0] a,
                         input logic [2:0] p);
    @(negedge clk_sys_i);
    cfg_write_i = 1'b1;
    cfg_wdata_i = '{m, a, p};
    @(negedge clk_sys_i);
    cfg_write_i = 1'b0;
  endtask

  // Ramps the sample until the done flag rises
  task automatic run_conv(output int act, output logic [15:0] last);
    int n;
    act = 0;
    n   = 0;
    while (data_ready_o !== 1'b1 && n < 2000) begin
      @(negedge clk_sys_i);
      n++;
      if (conv_active_o === 1'b1) act++;
      if (data_ready_o !== 1'b1) adc_sample_i = adc_sample_i + 16'h1;
    end
    last = adc_sample_i - 16'h1;
  endtask

  // Cycles until the next start of an active period
  task automatic next_start(output int n);
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (conv_active_o === 1'b1 && n < 9000);
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (conv_active_o !== 1'b1 && n < 9000);
  endtask

  task automatic one_shot(input logic [1:0] a, input logic [2:0] p,
                          input int k);
    int          act;
    logic [15:0] s;
    logic [15:0] e;
    logic [15:0] v;
    set_cfg(MODE_ONESHOT, a, p);
    run_conv(act, s);
    e = s - ((k == 8) ? 16'h23 : 16'h0);
    check(16'(act >= k * CV - 1 && act <= k * CV + 2), 16'h1);
    check(result_o, e);
    repeat (5) @(negedge clk_sys_i);
    check(16'(power_down_mode_o && !conv_active_o), 16'h1);
    check(16'(cfg_o.conversion_mode_select), 16'(MODE_SHUTDOWN));
    check(16'(data_ready_o), 16'h1);
    host.read_reg(1'b0, v);
    check(v, e);
    check(16'(data_ready_o), 16'h0);
  endtask

  task automatic cont(input logic [1:0] m);
    int          act;
    int          n;
    logic [15:0] s;
    set_cfg(m, AVG_NONE, 3'h0);
    run_conv(act, s);
    check(result_o, s);
    next_start(n);
    next_start(n);
    check(16'(n), 16'(PERIOD_MS[0] * MS));
  endtask

  task automatic abort_conv();
    int          n;
    logic [15:0] v;
    next_start(n);
    set_cfg(MODE_SHUTDOWN, AVG_NONE, 3'h0);
    host.read_reg(1'b1, v);
    repeat (3 * CV) @(negedge clk_sys_i);
    check(16'(conv_active_o), 16'h0);
    check(16'(data_ready_o), 16'h0);
  endtask

  task automatic bus_stall();
    logic mid;
    logic fin;
    host.stall(TO + 4, mid, fin);
    check(16'(mid), 16'h0);
    check(16'(fin), 16'h1);
    repeat (3) @(negedge clk_sys_i);
    check(16'(bus_timeout_o), 16'h0);
  endtask

  initial begin
    reset_i            = 1'b1;
    startup_shutdown_i = 1'b1;
    cfg_write_i        = 1'b0;
    cfg_wdata_i        = CFG_RESET;
    adc_sample_i       = 16'hffe0;
    do_reset(1'b1);
    one_shot(AVG_EIGHT, 3'h4, 8);
    one_shot(AVG_NONE, 3'h7, 1);
    one_shot(2'h3, 3'h0, 1);
    cont(MODE_CONT);
    abort_conv();
    cont(MODE_CONT_ALT);
    abort_conv();
    bus_stall();
    do_reset(1'b0);
    test_done();
  end

  initial begin
    #80000;
    fail_count++;
    test_done();
  end
endmodule
